// File: hw/awc_top.sv
// awc_top: window comparator, limits, channel select and sensor gating
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R01: less-than low byte at c5, reset zero
// R02: less-than high byte at c6, reset zero
// R03: greater-than low byte at c3, reset ones
// R04: compare result and limits as unsigned
// R05: inside mode: gt < word < lt
// R06: outside mode: word < gt or > lt
// R07: left-justified words compare the same way
// R08: 5-bit channel at bb, upper bits zero
// R09: codes 0-15 pick port 0/1 pins
// R10: temp, regulator, supply, ground, else none
// R11: sensor gated by reference enable bit
// R12: software selects sensor before converting it
// R13: software sets used pins analog mode
// R14: software skips used pins in crossbar
// R15: software does one-point offset calibration
// R16: one compare per conversion, sticky flag
module awc_top
	import awc_pkg::*;
(
	// clock, reset, enable
	input  wire  logic              clk,
	input  wire  logic              rstn,
	input  wire  logic              ce,
	// special function register port
	input  wire  logic [7:0]        sfr_addr,
	input  wire  logic              sfr_wr,
	input  wire  logic              sfr_rd,
	input  wire  logic [7:0]        sfr_wdata,
	output logic       [7:0]        sfr_rdata,
	// converter core result
	input  wire  logic              conv_done,
	input  wire  logic [RES_W-1:0]  conv_data,
	// analog multiplexer control
	output logic       [CHAN_W-1:0] positive_channel_code,
	output logic                    mux_port0_sel,
	output logic                    mux_port1_sel,
	output logic       [2:0]        mux_pin_sel,
	output logic                    mux_temp_sel,
	output logic                    mux_reg_sel,
	output logic                    mux_supply_sel,
	output logic                    mux_ground_sel,
	output logic                    mux_none_sel,
	// sensor and status
	output logic                    temp_sensor_enable,
	output logic                    window_compare_flag
);
	////////////////////////////////////////////////////////////////////////////
	// decoding functions

	// maps a channel code to its source
	function automatic awc_src_t chan_src(input logic [CHAN_W-1:0] code);
		if (code < CH_PORT1_FIRST) begin
			chan_src = SRC_PORT0;
		end else if (code < CH_TEMP) begin
			chan_src = SRC_PORT1;  // 16-pin parts treat the top four as reserved
		end else begin
			case (code)
				CH_TEMP:      chan_src = SRC_TEMP;
				CH_REGULATOR: chan_src = SRC_REG;
				CH_SUPPLY:    chan_src = SRC_SUPPLY;
				CH_GROUND:    chan_src = SRC_GROUND;
				default:      chan_src = SRC_NONE;
			endcase
		end
	endfunction : chan_src

	// justifies a raw result into a 16-bit word
	function automatic logic [15:0] justify(input logic [RES_W-1:0] d, input logic left);
		if (left) begin
			justify = {d, 6'h00};
		end else begin
			justify = {6'h00, d};
		end
	endfunction : justify

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [CHAN_W-1:0] chan;    // positive input code
		logic [7:0]        refc;    // reference control copy
		logic [15:0]       result;  // last justified result
		logic              flag;    // sticky window flag
		logic              mode;    // 1 outside window, 0 inside
		logic              left;    // left justification
	} awc_st_t;

	awc_st_t     st_q;          // registered state
	awc_st_t     st_d;          // next state
	logic [15:0] gt_limit;      // greater-than pair
	logic [15:0] lt_limit;      // less-than pair
	logic [15:0] new_word;      // justified incoming result
	logic        win_hit;       // comparison outcome
	logic        wr_ctrl;       // software write to control
	awc_src_t    src;           // decoded source
	logic        cdone_s1_q;    // completion synchroniser, first stage
	logic        cdone_s2_q;    // completion synchroniser, second stage
	logic        cdone_s3_q;    // delayed copy for edge detect
	logic [RES_W-1:0] cdat_s1_q;  // result synchroniser stages
	logic [RES_W-1:0] cdat_s2_q;
	logic        conv_evt;      // one pulse per conversion

	////////////////////////////////////////////////////////////////////////////
	// analog-side inputs pass two flops; data is stable once done rises

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cdone_s1_q <= 1'b0;
			cdone_s2_q <= 1'b0;
			cdone_s3_q <= 1'b0;
			cdat_s1_q  <= '0;
			cdat_s2_q  <= '0;
		end else if (ce) begin
			cdone_s1_q <= conv_done;
			cdone_s2_q <= cdone_s1_q;
			cdone_s3_q <= cdone_s2_q;
			cdat_s1_q  <= conv_data;
			cdat_s2_q  <= cdat_s1_q;
		end
	end

	// rising edge gives exactly one evaluation per conversion
	assign conv_evt = cdone_s2_q & ~cdone_s3_q;  // [R16]

	////////////////////////////////////////////////////////////////////////////
	// limit registers

	awc_limit_reg #(.RST_BYTE(RST_GT)) u_gt (  // [R03]
		.clk     (clk),
		.rstn    (rstn),
		.ce      (ce),
		.wr_low  (sfr_wr && sfr_addr == ADDR_GT_LOW),
		.wr_high (sfr_wr && sfr_addr == ADDR_GT_HIGH),
		.wdata   (sfr_wdata),
		.value   (gt_limit)
	);

	awc_limit_reg #(.RST_BYTE(RST_LT)) u_lt (  // [R01] [R02]
		.clk     (clk),
		.rstn    (rstn),
		.ce      (ce),
		.wr_low  (sfr_wr && sfr_addr == ADDR_LT_LOW),
		.wr_high (sfr_wr && sfr_addr == ADDR_LT_HIGH),
		.wdata   (sfr_wdata),
		.value   (lt_limit)
	);

	////////////////////////////////////////////////////////////////////////////
	// comparison on unsigned 16-bit words, using limits live at the result

	assign new_word = justify(cdat_s2_q, st_q.left);  // [R07]

	always_comb begin
		if (st_q.mode) begin
			win_hit = (new_word < gt_limit) || (new_word > lt_limit);  // [R06] [R04]
		end else begin
			win_hit = (new_word > gt_limit) && (new_word < lt_limit);  // [R05] [R04]
		end
	end

	assign wr_ctrl = sfr_wr && sfr_addr == ADDR_WIN_CTRL;

	////////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		st_d = st_q;
		if (sfr_wr) begin
			case (sfr_addr)
				ADDR_POS_INPUT_SEL: st_d.chan = sfr_wdata[CHAN_W-1:0];  // [R08]
				ADDR_REF_CTRL:      st_d.refc = sfr_wdata & REF_WMASK;
				ADDR_WIN_CTRL: begin
					st_d.mode = sfr_wdata[WIN_MODE_BIT];
					st_d.left = sfr_wdata[JUST_BIT];
					// only a written zero clears the flag
					if (!sfr_wdata[WIN_FLAG_BIT]) begin
						st_d.flag = 1'b0;
					end
				end
				default: ;  // other addresses belong to other blocks
			endcase
		end
		if (conv_evt) begin
			st_d.result = new_word;
			// a hit in the clearing cycle wins over the clear
			if (win_hit) begin
				st_d.flag = 1'b1;  // [R16]
			end
		end
	end

	// state register with clock enable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '{chan: RST_CHANNEL, refc: RST_REF, result: 16'h0000,
				flag: 1'b0, mode: 1'b0, left: 1'b0};
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data, registered; unmapped addresses read zero

	logic [7:0] rdata_q;  // read data register

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 8'h00;
		end else if (ce && sfr_rd) begin
			case (sfr_addr)
				ADDR_POS_INPUT_SEL: rdata_q <= {3'h0, st_q.chan};  // [R08]
				ADDR_GT_LOW:        rdata_q <= gt_limit[7:0];
				ADDR_GT_HIGH:       rdata_q <= gt_limit[15:8];
				ADDR_LT_LOW:        rdata_q <= lt_limit[7:0];  // [R01]
				ADDR_LT_HIGH:       rdata_q <= lt_limit[15:8];  // [R02]
				ADDR_RESULT_LOW:    rdata_q <= st_q.result[7:0];
				ADDR_RESULT_HIGH:   rdata_q <= st_q.result[15:8];
				ADDR_WIN_CTRL:      rdata_q <= {5'h00, st_q.left, st_q.mode, st_q.flag};
				ADDR_REF_CTRL:      rdata_q <= st_q.refc;
				default:            rdata_q <= 8'h00;
			endcase
		end
	end

	assign sfr_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// multiplexer control from the registered code

	assign src                   = chan_src(st_q.chan);  // [R09] [R10]
	assign positive_channel_code = st_q.chan;
	assign mux_port0_sel         = (src == SRC_PORT0);  // [R09]
	assign mux_port1_sel         = (src == SRC_PORT1);
	assign mux_pin_sel           = st_q.chan[2:0];
	assign mux_temp_sel          = (src == SRC_TEMP);  // [R10]
	assign mux_reg_sel           = (src == SRC_REG);
	assign mux_supply_sel        = (src == SRC_SUPPLY);
	assign mux_ground_sel        = (src == SRC_GROUND);
	assign mux_none_sel          = (src == SRC_NONE);
	// sensor powered only by its enable bit; disabled it floats
	assign temp_sensor_enable    = st_q.refc[TEMP_EN_BIT];  // [R11]
	assign window_compare_flag   = st_q.flag;

	////////////////////////////////////////////////////////////////////////////
	// assertions

	sequence s_conv_seen;
		$rose(cdone_s2_q);
	endsequence

	// software clear of the flag through the control register
	sequence s_flag_clear;
		ce && wr_ctrl && !sfr_wdata[WIN_FLAG_BIT];
	endsequence

	AST_LT_RESET: assert property (@(posedge clk) $rose(rstn) |-> lt_limit == 16'h0000)  // [R01]
		else $error("less-than limit not zero after reset");
	AST_LT_LOW: assert property (@(posedge clk) disable iff (!rstn)  // [R01]
		ce && sfr_wr && sfr_addr == ADDR_LT_LOW |=> lt_limit[7:0] == $past(sfr_wdata))
		else $error("less-than low byte not written");
	AST_LT_HIGH: assert property (@(posedge clk) disable iff (!rstn)  // [R02]
		ce && sfr_wr && sfr_addr == ADDR_LT_HIGH |=> lt_limit[15:8] == $past(sfr_wdata))
		else $error("less-than high byte not written");
	AST_GT_RESET: assert property (@(posedge clk) $rose(rstn) |-> gt_limit == 16'hffff)  // [R03]
		else $error("greater-than limit not all ones after reset");
	AST_GT_LOW: assert property (@(posedge clk) disable iff (!rstn)  // [R03]
		ce && sfr_wr && sfr_addr == ADDR_GT_LOW |=> gt_limit[7:0] == $past(sfr_wdata))
		else $error("greater-than low byte not written");
	AST_INSIDE: assert property (@(posedge clk) disable iff (!rstn)  // [R05]
		ce && conv_evt && !st_q.mode && new_word > gt_limit && new_word < lt_limit |=> st_q.flag)
		else $error("inside hit did not set flag");
	AST_OUTSIDE: assert property (@(posedge clk) disable iff (!rstn)  // [R06]
		ce && conv_evt && st_q.mode && (new_word < gt_limit || new_word > lt_limit)
		|=> st_q.flag)
		else $error("outside hit did not set flag");
	AST_LEFT: assert property (@(posedge clk) disable iff (!rstn)  // [R07]
		ce && conv_evt && st_q.left |=> st_q.result == {$past(cdat_s2_q), 6'h00})
		else $error("left justified result not stored in upper bits");
	AST_CHAN_RD: assert property (@(posedge clk) disable iff (!rstn)  // [R08]
		ce && sfr_rd && sfr_addr == ADDR_POS_INPUT_SEL |=> sfr_rdata[7:5] == 3'h0)
		else $error("channel register upper bits not zero");
	AST_TEMP_SEL: assert property (@(posedge clk) disable iff (!rstn)  // [R10]
		mux_temp_sel |-> st_q.chan == CH_TEMP && !mux_none_sel)
		else $error("temperature select mismatch");
	AST_ONEHOT: assert property (@(posedge clk) disable iff (!rstn)  // [R09] [R10]
		$onehot({mux_port0_sel, mux_port1_sel, mux_temp_sel, mux_reg_sel,
			mux_supply_sel, mux_ground_sel, mux_none_sel}))
		else $error("source select not one-hot");
	AST_PORT1: assert property (@(posedge clk) disable iff (!rstn)  // [R09]
		mux_port1_sel |-> st_q.chan[4:3] == 2'b01)
		else $error("port 1 select outside its codes");
	AST_SET: assert property (@(posedge clk) disable iff (!rstn)  // [R16]
		s_conv_seen ##0 (ce && win_hit) |=> window_compare_flag)
		else $error("window hit did not set flag");
	// a software clear may follow a set at once, so only an uncleared flag must stay
	AST_STICKY: assert property (@(posedge clk) disable iff (!rstn)  // [R16]
		window_compare_flag && !(ce && wr_ctrl && !sfr_wdata[WIN_FLAG_BIT])
		|=> window_compare_flag)
		else $error("window flag not held");
	AST_CLEAR: assert property (@(posedge clk) disable iff (!rstn)  // [R16]
		s_flag_clear ##0 !(conv_evt && win_hit) |=> !window_compare_flag)
		else $error("window flag not cleared by software");
	AST_SENSOR: assert property (@(posedge clk) disable iff (!rstn)  // [R11]
		ce && sfr_wr && sfr_addr == ADDR_REF_CTRL && sfr_wdata[TEMP_EN_BIT]
		|=> temp_sensor_enable)
		else $error("sensor not enabled by its bit");
	AST_SENSOR_OFF: assert property (@(posedge clk) disable iff (!rstn)  // [R11]
		ce && sfr_wr && sfr_addr == ADDR_REF_CTRL && !sfr_wdata[TEMP_EN_BIT]
		|=> !temp_sensor_enable)
		else $error("sensor not disabled by its bit");
endmodule : awc_top
`default_nettype wire

// File: hw/awc_pkg.sv
// awc_pkg: register addresses, reset values, field positions and channel codes
package awc_pkg;
	// special function register addresses
	localparam logic [7:0] ADDR_POS_INPUT_SEL = 8'hbb;
	localparam logic [7:0] ADDR_GT_LOW        = 8'hc3;
	localparam logic [7:0] ADDR_GT_HIGH       = 8'hc4;
	localparam logic [7:0] ADDR_LT_LOW        = 8'hc5;
	localparam logic [7:0] ADDR_LT_HIGH       = 8'hc6;
	localparam logic [7:0] ADDR_RESULT_LOW    = 8'hbd;
	localparam logic [7:0] ADDR_RESULT_HIGH   = 8'hbe;
	localparam logic [7:0] ADDR_WIN_CTRL      = 8'hbf;
	localparam logic [7:0] ADDR_REF_CTRL      = 8'hd1;
	// reset values
	localparam logic [7:0] RST_GT      = 8'hff;
	localparam logic [7:0] RST_LT      = 8'h00;
	localparam logic [4:0] RST_CHANNEL = 5'h1f;
	localparam logic [7:0] RST_REF     = 8'h10;
	// field positions
	localparam int CHAN_W       = 5;
	localparam int RES_W        = 10;
	localparam int WIN_FLAG_BIT = 0;
	localparam int WIN_MODE_BIT = 1;
	localparam int JUST_BIT     = 2;
	localparam int TEMP_EN_BIT  = 2;
	localparam logic [7:0] REF_WMASK = 8'h3e;
	// channel codes
	localparam logic [4:0] CH_PORT1_FIRST = 5'h08;
	localparam logic [4:0] CH_TEMP        = 5'h10;
	localparam logic [4:0] CH_REGULATOR   = 5'h11;
	localparam logic [4:0] CH_SUPPLY      = 5'h12;
	localparam logic [4:0] CH_GROUND      = 5'h13;
	// decoded source of the positive input
	typedef enum logic [2:0] {
		SRC_PORT0, SRC_PORT1, SRC_TEMP, SRC_REG, SRC_SUPPLY, SRC_GROUND, SRC_NONE
	} awc_src_t;
endpackage : awc_pkg

// File: hw/awc_limit_reg.sv
// awc_limit_reg: one 16-bit limit pair with byte-wide software writes
`timescale 1ns/1ns
`default_nettype none
module awc_limit_reg
	import awc_pkg::*;
#(
	parameter logic [7:0] RST_BYTE = 8'h00
)(
	// clock and reset
	input  wire  logic        clk,
	input  wire  logic        rstn,
	input  wire  logic        ce,
	// byte writes
	input  wire  logic        wr_low,
	input  wire  logic        wr_high,
	input  wire  logic [7:0]  wdata,
	// stored value, from a register
	output logic       [15:0] value
);
	typedef struct packed {
		logic [15:0] val;
	} awc_lim_st_t;

	awc_lim_st_t st_q;  // stored pair
	awc_lim_st_t st_d;  // next pair

	// byte lanes update independently so software may write either half first
	always_comb begin
		st_d = st_q;
		if (wr_low) begin
			st_d.val[7:0] = wdata;
		end
		if (wr_high) begin
			st_d.val[15:8] = wdata;
		end
	end

	// register with clock enable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '{val: {RST_BYTE, RST_BYTE}};
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign value = st_q.val;
endmodule : awc_limit_reg
`default_nettype wire

// File: test/awc_conv_model.sv
// awc_conv_model: converter core stand-in that hands results to the block
`timescale 1ns/1ns
`default_nettype none
module awc_conv_model (
	// clock
	input  wire logic       clk,
	// result handshake
	output var  logic       conv_done,
	output var  logic [9:0] conv_data
);
	// idle: no result pending, data pattern is meaningless
	initial begin
		conv_done = 1'b0;
		conv_data = 10'h155;
	end
	// inputs arrive already routed: used pins analog and skipped by the crossbar
	// one conversion; data held five cycles, well past the three the sync needs
	task automatic convert(input logic [9:0] v);
		@(posedge clk);
		#1 conv_data = v;
		conv_done = 1'b1;
		repeat (5) @(posedge clk);
		#1 conv_done = 1'b0;
		// stale data inverted so a late sample of it cannot pass by chance
		conv_data = ~v;
		repeat (3) @(posedge clk);
	endtask : convert
endmodule : awc_conv_model
`default_nettype wire

// File: test/awc_top_tb.sv
// awc_top_tb: register, channel decode and window compare checks
`timescale 1ns/1ns
`default_nettype none
module awc_top_tb
	import awc_pkg::*;
;
	logic       clk, rstn, ce, sfr_wr, sfr_rd;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rv;
	logic       conv_done;
	logic [9:0] conv_data;
	logic [4:0] code;
	logic [2:0] pin;
	wire  [6:0] sel;
	logic [6:0] exp_sel;
	logic       temp_en, flag;
	int         fail_count = 0;
	int         tests_run = 0;
	// window table: {just, mode}, raw word, expected flag
	logic [1:0] wc[16] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 3, 3, 3, 3};
	logic [9:0] wd[16] = '{10'h40, 10'h41, 10'hff, 10'h100, 10'h3ff, 10'h3f, 10'h40,
		10'h100, 10'h101, 10'h1, 10'h2, 10'h4, 10'h0, 10'h3, 10'h4, 10'h3ff};
	logic       we[16] = '{0, 1, 1, 0, 0, 1, 0, 0, 1, 0, 1, 0, 1, 0, 0, 1};
	////////////////////////////////////////////////////////////////////////////
	awc_top dut (.clk(clk), .rstn(rstn), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.conv_done(conv_done), .conv_data(conv_data), .positive_channel_code(code),
		.mux_port0_sel(sel[6]), .mux_port1_sel(sel[5]), .mux_pin_sel(pin),
		.mux_temp_sel(sel[4]), .mux_reg_sel(sel[3]), .mux_supply_sel(sel[2]),
		.mux_ground_sel(sel[1]), .mux_none_sel(sel[0]), .temp_sensor_enable(temp_en),
		.window_compare_flag(flag));
	awc_conv_model conv (.clk(clk), .conv_done(conv_done), .conv_data(conv_data));
	////////////////////////////////////////////////////////////////////////////
	// clock, 20 ns period
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// byte-wide compare
	task automatic chk_b(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_b
	// single-bit compare
	task automatic chk_f(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_f
	// register write: strobe held across exactly one taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk);
		#1 sfr_wr = 1'b0;
	endtask : wr
	// register read; data registered at the taking edge and held after
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		#1 sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clk);
		#1 sfr_rd = 1'b0;
		chk_b($sformatf("reg %h", a), e, sfr_rdata);
	endtask : rchk
	// verdict
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out
	// watchdog, far beyond the roughly 350 cycles the run needs
	initial begin
		#400000;
		fail_count++;
		$display("[ERR] watchdog expected finish seen hang");
		close_out();
	end
	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		repeat (8) @(posedge clk);
		#1 rstn = 1'b1;
		// reset values, unmapped read
		rchk(ADDR_GT_LOW, RST_GT);
		rchk(ADDR_GT_HIGH, RST_GT);
		rchk(ADDR_LT_LOW, RST_LT);
		rchk(ADDR_LT_HIGH, RST_LT);
		rchk(ADDR_POS_INPUT_SEL, {3'h0, RST_CHANNEL});
		rchk(ADDR_WIN_CTRL, 8'h00);
		rchk(ADDR_REF_CTRL, RST_REF);
		rchk(8'he0, 8'h00);
		// read/write, upper channel bits, ignored write
		wr(ADDR_LT_LOW, 8'ha5);
		rchk(ADDR_LT_LOW, 8'ha5);
		wr(ADDR_LT_HIGH, 8'h5a);
		rchk(ADDR_LT_HIGH, 8'h5a);
		wr(ADDR_GT_LOW, 8'h3c);
		rchk(ADDR_GT_LOW, 8'h3c);
		wr(ADDR_POS_INPUT_SEL, 8'hff);
		rchk(ADDR_POS_INPUT_SEL, 8'h1f);
		wr(8'he0, 8'h77);
		rchk(8'he0, 8'h00);
		// clock enable low must freeze the register
		ce = 1'b0;
		wr(ADDR_LT_LOW, 8'h11);
		ce = 1'b1;
		rchk(ADDR_LT_LOW, 8'ha5);
		// sensor enable through reference control
		wr(ADDR_REF_CTRL, 8'hff);
		rchk(ADDR_REF_CTRL, REF_WMASK);
		chk_f("temp_en", 1'b1, temp_en);
		wr(ADDR_REF_CTRL, 8'h00);
		chk_f("temp_en", 1'b0, temp_en);
		// every channel code, one-hot source and pin
		for (int c = 0; c < 32; c++) begin
			wr(ADDR_POS_INPUT_SEL, 8'(c));
			exp_sel = (c < 8) ? 7'h40 : (c < 16) ? 7'h20 : (c < 20) ? 7'h10 >> (c - 16) : 7'h01;
			chk_b("code", 8'(c), {3'h0, code});
			chk_b("source", {1'b0, exp_sel}, {1'b0, sel});
			chk_b("pin", 8'(c % 8), {5'h0, pin});
		end
		// window limits gt 0x0040, lt 0x0100; sensor selected before converting
		wr(ADDR_POS_INPUT_SEL, {3'h0, CH_TEMP});
		wr(ADDR_GT_LOW, 8'h40);
		wr(ADDR_GT_HIGH, 8'h00);
		wr(ADDR_LT_LOW, 8'h00);
		wr(ADDR_LT_HIGH, 8'h01);
		// writing the mode with bit0 low also clears the flag
		for (int i = 0; i < 16; i++) begin
			wr(ADDR_WIN_CTRL, {5'h0, wc[i], 1'b0});
			conv.convert(wd[i]);
			chk_f("flag", we[i], flag);
		end
		// flag sticky over a miss and a write of one
		wr(ADDR_WIN_CTRL, 8'h07);
		conv.convert(10'h004);
		chk_f("flag", 1'b1, flag);
		rchk(ADDR_RESULT_HIGH, 8'h01);
		rchk(ADDR_WIN_CTRL, 8'h07);
		wr(ADDR_WIN_CTRL, 8'h06);
		chk_f("flag", 1'b0, flag);
		// port pin conversion, right-justified inside window
		wr(ADDR_POS_INPUT_SEL, 8'h03);
		wr(ADDR_WIN_CTRL, 8'h00);
		conv.convert(10'h080);
		chk_f("flag", 1'b1, flag);
		// one-point offset: sensor converted at a known point, result kept as offset
		wr(ADDR_POS_INPUT_SEL, {3'h0, CH_TEMP});
		wr(ADDR_REF_CTRL, 8'h04);
		wr(ADDR_WIN_CTRL, 8'h00);
		conv.convert(10'h2c5);
		rchk(ADDR_RESULT_LOW, 8'hc5);
		rchk(ADDR_RESULT_HIGH, 8'h02);
		chk_f("flag", 1'b0, flag);
		close_out();
	end
endmodule : awc_top_tb
`default_nettype wire
